// ===== rtl/io_ports_pkg.sv
// package for the mode-dependent parallel port block
// assumes a single 25 MHz clock domain and a plain register port
package io_ports_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] port_a_data_off      = 8'h00;
  localparam logic [7:0] pulse_accum_ctrl_off = 8'h01;
  localparam logic [7:0] port_b_data_off      = 8'h02;
  localparam logic [7:0] port_b_direction_off = 8'h03;
  localparam logic [7:0] port_c_control_off   = 8'h04;
  localparam logic [7:0] port_c_data_off      = 8'h05;
  localparam logic [7:0] port_c_direction_off = 8'h06;
  localparam logic [7:0] port_d_data_off      = 8'h07;
  localparam logic [7:0] port_d_direction_off = 8'h08;
  localparam logic [7:0] mode_status_off      = 8'h09;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int wired_or_bit  = 5;
  localparam int pa7_dir_bit   = 7;
  localparam int pa3_dir_bit   = 3;
  localparam int strobe_bit    = 6;
  localparam int rw_bit        = 7;
  localparam int slave_sel_bit = 5;
  localparam int special_mode_flag_bit      = 1;
  localparam int mda_bit       = 0;
  localparam logic [7:0] port_a_out_fixed = 8'h70;
  localparam logic [7:0] port_a_in_fixed  = 8'h07;
  localparam logic [7:0] spi_pin_mask     = 8'h1c;
  localparam logic [7:0] data_reset       = 8'h00;
  localparam logic [7:0] dir_reset        = 8'h00;
  localparam logic [7:0] dir_all_out      = 8'hff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // code is {mode_pin_b, mode_pin_a} as latched, so straps map straight in
  typedef enum logic [1:0] {
    mode_bootstrap,
    mode_test,
    mode_single_chip,
    mode_expanded
  } op_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic       enable;
    logic       master;
    logic [7:0] spi_out;
    logic [7:0] spi_wants_out;
  } spi_ctl_t;

endpackage

// ===== rtl/pin_sync.sv
// two-flip-flop synchroniser for a vector of pin inputs
// assumes the pins are asynchronous to ref_clk
`timescale 1ns/1ps
module pin_sync #(
  parameter int width = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);
  if (width < 1) begin : g_width_check
    $error("pin_sync width must be at least one");
  end

  logic [width-1:0] stage_one;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule // pin_sync

// ===== rtl/io_ports.sv
// four parallel ports; the roles of ports B, C and D follow the latched operating mode
// assumes one clock, a single-cycle register port and tristate pads outside
`timescale 1ns/1ps

module io_ports (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // register port
  input  wire io_ports_pkg::reg_req_t req,
  output logic                  [7:0] rdata,
  // mode straps
  input  wire logic                   mode_pin_a,
  input  wire logic                   mode_pin_b,
  // timer side of port A
  input  wire logic             [7:0] compare_enable,
  input  wire logic             [7:0] compare_value,
  output logic                  [7:0] timer_pin_in,
  // spi and sci side of port D
  input  wire io_ports_pkg::spi_ctl_t spi,
  input  wire logic             [7:0] sci_out,
  input  wire logic             [7:0] sci_oe,
  output logic                  [7:0] serial_pin_in,
  // expansion bus
  input  wire logic                   bus_active,
  input  wire logic                   bus_addr_phase,
  input  wire logic                   bus_read,
  input  wire logic            [15:0] bus_addr,
  input  wire logic             [7:0] bus_wdata,
  output logic                  [7:0] bus_rdata,
  // pads
  input  wire logic             [7:0] pa_in,
  output logic                  [7:0] pa_out,
  output logic                  [7:0] pa_oe,
  input  wire logic             [7:0] pb_in,
  output logic                  [7:0] pb_out,
  output logic                  [7:0] pb_oe,
  input  wire logic             [7:0] pc_in,
  output logic                  [7:0] pc_out,
  output logic                  [7:0] pc_oe,
  input  wire logic             [7:0] pd_in,
  output logic                  [7:0] pd_out,
  output logic                  [7:0] pd_oe,
  output logic                  [1:0] op_mode
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [33:0] pins_sync;
  logic [7:0]  pa_s;
  logic [7:0]  pb_s;
  logic [7:0]  pc_s;
  logic [7:0]  pd_s;
  logic [1:0]  mode_s;

  pin_sync #(.width(34)) u_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in ({mode_pin_b, mode_pin_a, pd_in, pc_in, pb_in, pa_in}),
    .sync_out (pins_sync)
  );

  assign pa_s   = pins_sync[7:0];
  assign pb_s   = pins_sync[15:8];
  assign pc_s   = pins_sync[23:16];
  assign pd_s   = pins_sync[31:24];
  assign mode_s = pins_sync[33:32];

  // ----------------------------------------------------------------
  // mode capture
  // ----------------------------------------------------------------
  // the straps are caught on the first edge after the synchroniser has
  // refilled, so the flop itself resets to a constant
  io_ports_pkg::op_mode_t mode;
  logic [1:0]             settle;
  logic                   mode_taken;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle     <= 2'h0;
      mode_taken <= 1'b0;
      mode       <= io_ports_pkg::mode_single_chip;
    end else if (!mode_taken) begin
      settle <= settle + 2'h1;
      if (settle == 2'h2) begin
        mode_taken <= 1'b1;
        mode       <= io_ports_pkg::op_mode_t'(mode_s);
      end
    end
  end

  wire bus_mode    = (mode == io_ports_pkg::mode_expanded) || (mode == io_ports_pkg::mode_test);
  wire gpio_mode   = !bus_mode;
  wire expand_bus  = !gpio_mode && mode_taken;
  assign op_mode   = mode;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] port_a_data;
  logic [7:0] pulse_accum_control;
  logic [7:0] port_b_data;
  logic [7:0] port_b_direction;
  logic [7:0] port_c_control;
  logic [7:0] port_c_data;
  logic [7:0] port_c_direction;
  logic [7:0] port_d_data;
  logic [7:0] port_d_direction;

  wire wr_a    = req.wr && (req.addr == io_ports_pkg::port_a_data_off);
  wire wr_pac  = req.wr && (req.addr == io_ports_pkg::pulse_accum_ctrl_off);
  wire wr_b    = req.wr && (req.addr == io_ports_pkg::port_b_data_off);
  wire wr_bdir = req.wr && (req.addr == io_ports_pkg::port_b_direction_off);
  wire wr_cctl = req.wr && (req.addr == io_ports_pkg::port_c_control_off);
  wire wr_c    = req.wr && (req.addr == io_ports_pkg::port_c_data_off);
  wire wr_cdir = req.wr && (req.addr == io_ports_pkg::port_c_direction_off);
  wire wr_d    = req.wr && (req.addr == io_ports_pkg::port_d_data_off);
  wire wr_ddir = req.wr && (req.addr == io_ports_pkg::port_d_direction_off);

  // the latch always stores; only the output mux decides what reaches a pin
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_data         <= io_ports_pkg::data_reset;
      pulse_accum_control <= io_ports_pkg::dir_reset;
      port_b_data         <= io_ports_pkg::data_reset;
      port_b_direction    <= io_ports_pkg::dir_reset;
      port_c_control      <= io_ports_pkg::data_reset;
      port_c_data         <= io_ports_pkg::data_reset;
      port_c_direction    <= io_ports_pkg::dir_reset;
      port_d_data         <= io_ports_pkg::data_reset;
      port_d_direction    <= io_ports_pkg::dir_reset;
    end else begin
      if (wr_a)    port_a_data         <= req.wdata;
      if (wr_pac)  pulse_accum_control <= req.wdata;
      if (wr_b)    port_b_data         <= req.wdata;
      if (wr_bdir) port_b_direction    <= req.wdata;
      if (wr_cctl) port_c_control      <= req.wdata;
      if (wr_c)    port_c_data         <= req.wdata;
      if (wr_cdir) port_c_direction    <= req.wdata;
      if (wr_d)    port_d_data         <= req.wdata;
      if (wr_ddir) port_d_direction    <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // port A
  // ----------------------------------------------------------------
  logic [7:0] pa_dir;
  logic [7:0] pa_drv;

  always_comb begin
    pa_dir = io_ports_pkg::port_a_out_fixed;
    pa_dir[io_ports_pkg::pa7_dir_bit] = compare_enable[7] ||
                                        pulse_accum_control[io_ports_pkg::pa7_dir_bit];
    pa_dir[io_ports_pkg::pa3_dir_bit] = compare_enable[3] ||
                                        pulse_accum_control[io_ports_pkg::pa3_dir_bit];
    pa_dir = pa_dir & ~io_ports_pkg::port_a_in_fixed;
  end

  // a compare-owned pin follows the timer, so a write cannot disturb it
  assign pa_drv = (compare_enable & compare_value) | (~compare_enable & port_a_data);
  assign pa_out = pa_drv;
  assign pa_oe  = pa_dir;
  assign timer_pin_in = pa_s;

  // ----------------------------------------------------------------
  // port B
  // ----------------------------------------------------------------
  wire [7:0] pb_dir = expand_bus ? io_ports_pkg::dir_all_out : port_b_direction;
  wire [7:0] pb_drv = expand_bus ? bus_addr[15:8] : port_b_data;
  assign pb_out = pb_drv;
  assign pb_oe  = pb_dir;

  // ----------------------------------------------------------------
  // port C
  // ----------------------------------------------------------------
  logic [7:0] pc_dir;
  logic [7:0] pc_drv;

  always_comb begin
    if (expand_bus) begin
      if (bus_active && bus_addr_phase) begin
        pc_drv = bus_addr[7:0];
        pc_dir = io_ports_pkg::dir_all_out;
      end else begin
        pc_drv = bus_wdata;
        pc_dir = (bus_active && !bus_read) ? io_ports_pkg::dir_all_out : 8'h00;
      end
    end else begin
      pc_drv = port_c_data;
      pc_dir = port_c_direction;
    end
  end

  wire wired_or = port_c_control[io_ports_pkg::wired_or_bit];
  assign pc_out = wired_or ? 8'h00 : pc_drv;
  // open drain: drive only the zeros, let the ones float high
  assign pc_oe  = wired_or ? (pc_dir & ~pc_drv) : pc_dir;
  assign bus_rdata = pc_s;

  // ----------------------------------------------------------------
  // port D
  // ----------------------------------------------------------------
  logic [7:0] pd_dir;
  logic [7:0] pd_drv;

  always_comb begin
    pd_dir = port_d_direction;
    pd_drv = port_d_data;
    for (int i = 0; i < 2; i++) begin
      if (sci_oe[i]) begin
        pd_dir[i] = 1'b1;
        pd_drv[i] = sci_out[i];
      end
    end
    if (spi.enable) begin
      for (int i = 2; i < 5; i++) begin
        if (io_ports_pkg::spi_pin_mask[i]) begin
          pd_dir[i] = spi.spi_wants_out[i] && port_d_direction[i];
          pd_drv[i] = spi.spi_out[i];
        end
      end
      if (!spi.master)
        pd_dir[io_ports_pkg::slave_sel_bit] = 1'b0;
    end
    if (expand_bus) begin
      pd_dir[io_ports_pkg::strobe_bit] = 1'b1;
      pd_drv[io_ports_pkg::strobe_bit] = bus_active && bus_addr_phase;
      pd_dir[io_ports_pkg::rw_bit]     = 1'b1;
      pd_drv[io_ports_pkg::rw_bit]     = !bus_active || bus_read;
    end
  end

  // in spi master mode bit 5 keeps the direction register's choice
  assign pd_out = pd_drv;
  assign pd_oe  = pd_dir;
  assign serial_pin_in = pd_s;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  function automatic logic [7:0] port_view(input logic [7:0] dir,
                                           input logic [7:0] drv,
                                           input logic [7:0] pin);
    port_view = (dir & drv) | (~dir & pin);
  endfunction

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    unique case (req.addr)
      io_ports_pkg::port_a_data_off:      next_rdata = port_view(pa_dir, pa_drv, pa_s);
      io_ports_pkg::pulse_accum_ctrl_off: next_rdata = pulse_accum_control;
      io_ports_pkg::port_b_data_off:      next_rdata = port_view(pb_dir, pb_drv, pb_s);
      io_ports_pkg::port_b_direction_off: next_rdata = port_b_direction;
      io_ports_pkg::port_c_control_off:   next_rdata = port_c_control;
      io_ports_pkg::port_c_data_off:      next_rdata = port_view(pc_dir, pc_drv, pc_s);
      io_ports_pkg::port_c_direction_off: next_rdata = port_c_direction;
      io_ports_pkg::port_d_data_off:      next_rdata = port_view(pd_dir, pd_drv, pd_s);
      io_ports_pkg::port_d_direction_off: next_rdata = port_d_direction;
      io_ports_pkg::mode_status_off:      next_rdata = {6'h00, mode};
      default:                            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (req.rd)
      rdata <= next_rdata;
    else
      rdata <= 8'h00;
  end

endmodule // io_ports

// ===== dv/io_ports_checker.sv
// concurrent checks on the parallel port block
// assumes it is bound to io_ports and sees only its ports
`timescale 1ns/1ps
module io_ports_checker (
  input logic                   ref_clk,
  input logic                   rst_b,
  input io_ports_pkg::reg_req_t req,
  input logic             [7:0] rdata,
  input logic                   mode_pin_a,
  input logic                   mode_pin_b,
  input logic             [7:0] compare_enable,
  input logic             [7:0] compare_value,
  input io_ports_pkg::spi_ctl_t spi,
  input logic                   bus_active,
  input logic                   bus_addr_phase,
  input logic                   bus_read,
  input logic            [15:0] bus_addr,
  input logic             [7:0] pa_out,
  input logic             [7:0] pa_oe,
  input logic             [7:0] pb_out,
  input logic             [7:0] pb_oe,
  input logic             [7:0] pc_out,
  input logic             [7:0] pc_oe,
  input logic             [7:0] pd_oe,
  input logic             [1:0] op_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // the mode sync takes two edges, so allow four after release
  a_mode_from_pins: assert property ($rose(rst_b) |-> ##4 op_mode == {mode_pin_b, mode_pin_a})
    else $error("mode not taken from strap pins");
  a_rdata_idle: assert property (!req.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (req.rd && req.addr > 8'h09 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pa_fixed_dir: assert property (pa_oe[6:4] == 3'b111 && pa_oe[2:0] == 3'b000)
    else $error("port a fixed directions wrong");
  a_pa_compare_own: assert property (compare_enable[7] |-> pa_oe[7] && pa_out[7] == compare_value[7])
    else $error("compare does not own port a bit 7");
  a_pa3_compare_own: assert property (compare_enable[3] |-> pa_oe[3] && pa_out[3] == compare_value[3])
    else $error("compare does not own port a bit 3");
  a_pb_high_addr: assert property (op_mode[0] |-> pb_oe == 8'hff && pb_out == bus_addr[15:8])
    else $error("port b not upper address");
  a_pc_addr_phase: assert property (op_mode == 2'h3 && bus_active && bus_addr_phase
                                    |-> pc_oe == 8'hff && pc_out == bus_addr[7:0])
    else $error("port c not low address");
  a_pc_read_float: assert property (op_mode == 2'h3 && bus_active && !bus_addr_phase && bus_read
                                    |-> pc_oe == 8'h00)
    else $error("port c drives during read");
  a_pd_bus_lines: assert property (op_mode[0] |-> pd_oe[7:6] == 2'b11)
    else $error("strobe or read write not driven");
  a_spi_slave_in: assert property (spi.enable && !spi.master |-> !pd_oe[5])
    else $error("slave select driven in slave");
  a_spi_inputs: assert property (spi.enable |-> (pd_oe & ~spi.spi_wants_out & 8'h1c) == 8'h00)
    else $error("spi input pin driven");
  c_expanded: cover property (op_mode == 2'h3 && bus_active);
  c_compare: cover property (compare_enable[3]);
  c_spi_master: cover property (spi.enable && spi.master);
endmodule // io_ports_checker

bind io_ports io_ports_checker i_io_ports_checker (
  .ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .mode_pin_a(mode_pin_a),
  .mode_pin_b(mode_pin_b), .compare_enable(compare_enable), .compare_value(compare_value),
  .spi(spi), .bus_active(bus_active), .bus_addr_phase(bus_addr_phase), .bus_read(bus_read),
  .bus_addr(bus_addr), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
  .pc_out(pc_out), .pc_oe(pc_oe), .pd_oe(pd_oe), .op_mode(op_mode));

// ===== dv/pad_partner.sv
// external devices on the four ports
// assumes undriven lines are held by the bench pattern in ext
`timescale 1ns/1ps
module pad_partner (
  input  logic [3:0][7:0] ext,
  input  logic      [7:0] pa_out,
  input  logic      [7:0] pa_oe,
  input  logic      [7:0] pb_out,
  input  logic      [7:0] pb_oe,
  input  logic      [7:0] pc_out,
  input  logic      [7:0] pc_oe,
  input  logic      [7:0] pd_out,
  input  logic      [7:0] pd_oe,
  output logic      [7:0] pa_in,
  output logic      [7:0] pb_in,
  output logic      [7:0] pc_in,
  output logic      [7:0] pd_in
);
  // a driven bit shows the drive, a released bit the far side's level
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext[0]);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext[1]);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext[2]);
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext[3]);
endmodule // pad_partner

// ===== dv/testbench.sv
// self-checking bench for the parallel port block
// assumes io_ports, its checker bind and pad_partner
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, rst_b = 1'b0, mode_pin_a, mode_pin_b, bus_active, bus_addr_phase, bus_read;
  io_ports_pkg::reg_req_t req;
  io_ports_pkg::spi_ctl_t spi;
  logic [7:0] compare_enable, compare_value, sci_out, sci_oe, bus_wdata, rdata, timer_pin_in;
  logic [7:0] serial_pin_in, bus_rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
  logic [7:0] pc_in, pc_out, pc_oe, pd_in, pd_out, pd_oe, seed, d, v;
  logic [15:0] bus_addr;
  logic [1:0] op_mode;
  logic [3:0][7:0] ext;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  int err_total = 0, checks_done = 0;
  wire [3:0][7:0] oes = {pd_oe, pc_oe, pb_oe, pa_oe};
  wire [3:0][7:0] outs = {pd_out, pc_out, pb_out, pa_out};
  // data and direction offsets of ports b, c and d
  logic [7:0] dat_off[3] = '{8'h02, 8'h05, 8'h07};
  logic [7:0] dir_off[3] = '{8'h03, 8'h06, 8'h08};
  always #20 ref_clk = ~ref_clk;
  io_ports i_io_ports (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .compare_enable(compare_enable),
    .compare_value(compare_value), .timer_pin_in(timer_pin_in), .spi(spi), .sci_out(sci_out),
    .sci_oe(sci_oe), .serial_pin_in(serial_pin_in), .bus_active(bus_active),
    .bus_addr_phase(bus_addr_phase), .bus_read(bus_read), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .pd_in(pd_in),
    .pd_out(pd_out), .pd_oe(pd_oe), .op_mode(op_mode));
  pad_partner i_pad_partner (.ext(ext), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .pc_out(pc_out), .pc_oe(pc_oe), .pd_out(pd_out), .pd_oe(pd_oe), .pa_in(pa_in), .pb_in(pb_in),
    .pc_in(pc_in), .pd_in(pd_in));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
  endtask
  // releases the port, then lets synced pin levels catch up
  task automatic settle();
    @(posedge ref_clk);
    req <= '0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset(input logic a, input logic b);
    rst_b <= 1'b0;
    mode_pin_a <= a;
    mode_pin_b <= b;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) rd_seen <= req.rd;
  always @(negedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    summarize();
  end
  initial begin
    req = '0; spi = '0; compare_enable = 8'h00; compare_value = 8'h00; sci_out = 8'h00; sci_oe = 8'h00;
    bus_active = 1'b0; bus_addr_phase = 1'b0; bus_read = 1'b1; bus_addr = 16'h0000; bus_wdata = 8'h00;
    mode_pin_a = 1'b1; mode_pin_b = 1'b0; seed = 8'h50; ext = 32'h5a3c96e1;
    do_reset(1'b0, 1'b1);
    chk({6'h00, op_mode}, 8'h02);
    chk(pa_oe, 8'h70);
    chk(pa_out & 8'h70, 8'h00);
    chk(pb_oe | pc_oe | pd_oe, 8'h00);
    chk(timer_pin_in, ext[0] & 8'h8f);
    chk(serial_pin_in, ext[3]);
    rd(8'h00, ext[0] & 8'h8f);
    rd(8'h02, ext[1]);
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h3f, 8'h00);
    rd(8'h09, 8'h02);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed); d = seed; seed = lfsr(seed); v = seed;
      wr(dir_off[k], d);
      wr(dat_off[k], v);
      settle();
      chk(oes[k+1], d);
      chk(outs[k+1] & d, v & d);
      rd(dat_off[k], (v & d) | (~d & ext[k+1]));
      rd(dir_off[k], d);
      settle();
    end
    wr(8'h06, 8'h0f);
    wr(8'h05, 8'h05);
    wr(8'h04, 8'h20);
    settle();
    chk(pc_out, 8'h00);
    chk(pc_oe, 8'h0a);
    wr(8'h04, 8'h00);
    settle();
    chk(pc_out & pc_oe, 8'h05);
    wr(8'h01, 8'h88);
    wr(8'h00, 8'hff);
    settle();
    chk(pa_oe, 8'hf8);
    chk(pa_out & pa_oe, 8'hf8);
    wr(8'h01, 8'h00);
    compare_enable <= 8'h08;
    settle();
    chk(pa_oe, 8'h78);
    chk(pa_out & 8'h78, 8'h70);
    rd(8'h00, 8'h70 | (ext[0] & 8'h87));
    compare_enable <= 8'h00;
    spi <= '{enable: 1'b1, master: 1'b0, spi_out: 8'hff, spi_wants_out: 8'h00};
    wr(8'h08, 8'h3c);
    settle();
    chk(pd_oe & 8'h3c, 8'h00);
    spi <= '{enable: 1'b1, master: 1'b1, spi_out: 8'hff, spi_wants_out: 8'h1c};
    settle();
    chk(pd_oe & 8'h3c, 8'h3c);
    wr(8'h08, 8'h00);
    settle();
    chk(pd_oe & 8'h3c, 8'h00);
    spi <= '0;
    do_reset(1'b1, 1'b1);
    chk({6'h00, op_mode}, 8'h03);
    seed = lfsr(seed);
    bus_addr <= {seed, ~seed};
    bus_active <= 1'b1;
    bus_addr_phase <= 1'b1;
    wr(8'h03, 8'hff);
    wr(8'h02, 8'h00);
    settle();
    chk(pb_oe, 8'hff);
    chk(pb_out, seed);
    chk(pc_out, ~seed);
    chk(pd_oe & 8'hc0, 8'hc0);
    chk(pd_out & 8'hc0, 8'hc0);
    bus_addr_phase <= 1'b0;
    bus_read <= 1'b0;
    bus_wdata <= 8'h96;
    settle();
    chk(pc_oe, 8'hff);
    chk(pc_out, 8'h96);
    chk(pd_out & 8'hc0, 8'h00);
    bus_read <= 1'b1;
    settle();
    chk(pc_oe, 8'h00);
    chk(pd_out & 8'h80, 8'h80);
    chk(bus_rdata, ext[2]);
    do_reset(1'b1, 1'b0);
    chk({6'h00, op_mode}, 8'h01);
    chk(pb_oe, 8'hff);
    chk(pd_oe & 8'hc0, 8'hc0);
    do_reset(1'b0, 1'b0);
    chk({6'h00, op_mode}, 8'h00);
    chk(pb_oe | pc_oe | pd_oe, 8'h00);
    summarize();
  end
endmodule // testbench
